/* File: design/iopc_pkg.sv */
// shared types and constants for the port access checker
package iopc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // port space
  localparam int IOPC_PORT_W = 16;
  localparam logic [16:0] IOPC_PORT_LAST = 17'h0FFFF;
  localparam int IOPC_MAP_IDX_LSB = 3;
  localparam logic [7:0] IOPC_BYTE_ALL_SET = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // privilege and reset values
  localparam logic [1:0] IOPC_PRIV_TOP = 2'h0;
  localparam logic [1:0] IOPC_THR_RST = 2'h0;
  localparam logic IOPC_IRQ_RST = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // operations and element sizes
  typedef enum logic [2:0] {
    IOPC_OP_PORT_RD,
    IOPC_OP_PORT_WR,
    IOPC_OP_STR_RD,
    IOPC_OP_STR_WR,
    IOPC_OP_IRQ_MASK,
    IOPC_OP_IRQ_UNMASK,
    IOPC_OP_FLAGS_RESTORE,
    IOPC_OP_TRAP_RETURN
  } iopc_op_t;

  typedef enum logic [1:0] {
    IOPC_SZ_8,
    IOPC_SZ_16,
    IOPC_SZ_32
  } iopc_sz_t;

  ////////////////////////////////////////////////////////////////////////////
  // request from the pipeline and cycle toward the port bus
  typedef struct packed {
    iopc_op_t op;
    iopc_sz_t size;
    logic imm_port;
    logic [15:0] imm;
    logic [15:0] port_number_reg;
    logic block_loop_prefix;
    logic [31:0] count;
    logic [31:0] accumulator_reg;
    logic [31:0] source_ptr_reg;
    logic [31:0] dest_ptr_reg;
    logic [1:0] new_threshold;
    logic new_irq_allow;
  } iopc_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic io_space;
    logic [15:0] addr;
    iopc_sz_t size;
    logic [31:0] wdata;
  } iopc_pbus_t;

endpackage

/* File: design/iopc_bitmap_check.sv */
// permission bitmap window test for one port access
module iopc_bitmap_check
  import iopc_pkg::*;
(
  input wire logic [15:0] port,
  input iopc_sz_t size,
  input wire logic [15:0] map_bytes,
  input wire logic [15:0] map_base,
  input wire logic [31:0] seg_limit,
  output logic [31:0] byte_addr,
  output logic no_map,
  output logic deny
);

  logic b0_in;
  logic b1_in;
  logic [15:0] eff;
  logic [15:0] window;
  logic [3:0] mask;
  logic [16:0] last_port;
  logic wraps;

  // byte holding the first port's bit, located from the map base
  assign byte_addr = {16'h0000, map_base} + {19'h00000, port[15:IOPC_MAP_IDX_LSB]};
  assign no_map = ({16'h0000, map_base} >= seg_limit);

  // bytes past the segment limit read as all set
  assign b0_in = (byte_addr <= seg_limit);
  assign b1_in = ((byte_addr + 32'h00000001) <= seg_limit);
  assign eff = {(b1_in ? map_bytes[15:8] : IOPC_BYTE_ALL_SET),
                (b0_in ? map_bytes[7:0] : IOPC_BYTE_ALL_SET)};
  assign window = eff >> port[2:0];

  always_comb
  begin
    mask = 4'h1;
    last_port = {1'b0, port};
    case (size)
      IOPC_SZ_8:
      begin
        mask = 4'h1;
        last_port = {1'b0, port};
      end
      IOPC_SZ_16:
      begin
        mask = 4'h3;
        last_port = {1'b0, port} + 17'h00001;
      end
      IOPC_SZ_32:
      begin
        mask = 4'hF;
        last_port = {1'b0, port} + 17'h00003;
      end
      default:
      begin
        mask = 4'hF;
        last_port = {1'b0, port};
      end
    endcase
  end

  // R19 past top of port space refused
  assign wraps = (last_port > IOPC_PORT_LAST);
  assign deny = no_map | wraps | (|(window[3:0] & mask));

endmodule

/* File: design/iopc_checker.sv */
// privilege check, bitmap lookup and dispatch of port space accesses

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1: port, string port and irq mask/unmask ops fault when level exceeds threshold; the code faults port ops there only on a bitmap deny.
// R2: threshold changes only by flags restore or trap return at level 0.
// R3: flags restore changes irq allow only when level is within threshold.
// R4: protected mode within threshold: access allowed, bitmap not read.
// R5: above threshold or virtual-8086 mode: every access checked in the bitmap.
// R6: port bit is bit port mod 8 of bitmap byte port div 8.
// R7: every byte port of the access width tested; any set bit faults.
// R8: two consecutive bitmap bytes fetched from the first port's byte.
// R9: software puts an all-ones byte after the bitmap inside the limit.
// R10: bitmap bytes beyond the segment limit count as set bits.
// R11: map base at or past the limit means no map; all checked ops fault.
// R12: bitmap located from the current task's map base offset.
// R13: port ops use only the port space, never memory space.
// R14: single ops move 8/16/32 bits with accumulator; immediate or register port.
// R15: string ops take port register, source or destination pointer.
// R16: under loop prefix the pointer steps by element size per direction flag.
// R17: external decode holds cache allow pin high for mapped device ranges.
// R18: a set page no-cache bit suppresses caching of that page.
// R19: port space is 64K byte ports; 2 or 4 adjacent form wider ports.
// R20: all checks and faults finish before any port bus cycle starts.
module iopc_checker
  import iopc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic REQ_VALID,
  input iopc_req_t REQ,
  output logic REQ_READY,
  input wire logic PROT_MODE,
  input wire logic V86_MODE,
  input wire logic [1:0] RUNNING_PRIV_LEVEL,
  input wire logic STEP_DIRECTION_FLAG,
  input wire logic [15:0] TCS_MAP_BASE,
  input wire logic [31:0] TCS_LIMIT,
  output logic TCS_RD_REQ,
  output logic [31:0] TCS_RD_ADDR,
  input wire logic TCS_RD_VALID,
  input wire logic [15:0] TCS_RD_DATA,
  output logic MEM_RD_REQ,
  output logic MEM_WR_REQ,
  output logic [31:0] MEM_ADDR,
  output logic [31:0] MEM_WDATA,
  input wire logic MEM_RD_VALID,
  input wire logic [31:0] MEM_RD_DATA,
  input wire logic MEM_WR_ACK,
  output iopc_pbus_t PBUS,
  input wire logic PBUS_ACK,
  input wire logic [31:0] PBUS_RDATA,
  output logic DONE,
  output logic PROTECTION_FAULT,
  output logic [31:0] ACC_OUT,
  output logic [31:0] PTR_OUT,
  output logic [31:0] COUNT_OUT,
  output logic [1:0] IO_PRIV_THRESHOLD,
  output logic IRQ_ALLOW,
  input wire logic CACHE_ALLOW_N,
  input wire logic PAGE_NOCACHE_BIT,
  output logic LINE_CACHEABLE
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EVAL,
    ST_MAP_RD,
    ST_MEM_RD,
    ST_BUS,
    ST_MEM_WR,
    ST_NEXT
  } iopc_state_t;

  iopc_state_t state;
  iopc_state_t next_state;
  iopc_state_t post_chk;
  iopc_req_t req;
  logic [31:0] ptr;
  logic [31:0] count;
  logic [31:0] step;
  logic [31:0] elem_data;
  logic [1:0] thr;
  logic irq;
  logic chk_ok;
  logic [15:0] port_sel;
  logic is_str;
  logic is_port_op;
  logic need_map;
  logic irq_ok;
  logic map_deny;
  logic map_none;
  logic last_elem;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the held request and of the incoming op
  assign is_str = (req.op == IOPC_OP_STR_RD) || (req.op == IOPC_OP_STR_WR);
  assign is_port_op = (REQ.op == IOPC_OP_PORT_RD) || (REQ.op == IOPC_OP_PORT_WR) ||
                      (REQ.op == IOPC_OP_STR_RD) || (REQ.op == IOPC_OP_STR_WR);
  // R15 string port from register
  assign port_sel = (req.imm_port && !is_str) ? req.imm : req.port_number_reg;
  // R5 bitmap needed above threshold or in v86
  assign need_map = PROT_MODE && (V86_MODE || (RUNNING_PRIV_LEVEL > thr));
  // R1 level against threshold
  assign irq_ok = !PROT_MODE || (RUNNING_PRIV_LEVEL <= thr);
  assign post_chk = (req.op == IOPC_OP_STR_WR) ? ST_MEM_RD : ST_BUS;
  assign last_elem = !req.block_loop_prefix || (count == 32'h00000001);

  always_comb
  begin
    step = 32'h00000001;
    case (req.size)
      IOPC_SZ_8: step = 32'h00000001;
      IOPC_SZ_16: step = 32'h00000002;
      IOPC_SZ_32: step = 32'h00000004;
      default: step = 32'h00000001;
    endcase
  end

  // R6 bit position and byte index
  // R8 two byte window
  // R10 beyond limit reads as set
  iopc_bitmap_check u_map (
    .port(port_sel),
    .size(req.size),
    .map_bytes(TCS_RD_DATA),
    .map_base(TCS_MAP_BASE),
    .seg_limit(TCS_LIMIT),
    .byte_addr(TCS_RD_ADDR),
    .no_map(map_none),
    .deny(map_deny)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (REQ_VALID && is_port_op)
        begin
          next_state = ST_EVAL;
        end
      end
      ST_EVAL:
      begin
        if (req.block_loop_prefix && (count == 32'h00000000))
        begin
          next_state = ST_IDLE;
        end
        else if (need_map)
        begin
          next_state = map_none ? ST_IDLE : ST_MAP_RD;
        end
        else
        begin
          // R4 no bitmap read within threshold
          next_state = post_chk;
        end
      end
      ST_MAP_RD:
      begin
        if (TCS_RD_VALID)
        begin
          next_state = map_deny ? ST_IDLE : post_chk;
        end
      end
      ST_MEM_RD:
      begin
        if (MEM_RD_VALID)
        begin
          next_state = ST_BUS;
        end
      end
      ST_BUS:
      begin
        if (PBUS_ACK)
        begin
          if (req.op == IOPC_OP_STR_RD)
          begin
            next_state = ST_MEM_WR;
          end
          else if (req.op == IOPC_OP_STR_WR)
          begin
            next_state = ST_NEXT;
          end
          else
          begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_MEM_WR:
      begin
        if (MEM_WR_ACK)
        begin
          next_state = ST_NEXT;
        end
      end
      ST_NEXT:
      begin
        next_state = last_elem ? ST_IDLE : ST_EVAL;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request, pointer and element count
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      req <= '0;
      ptr <= 32'h00000000;
      count <= 32'h00000000;
    end
    else if (state == ST_IDLE && REQ_VALID)
    begin
      req <= REQ;
      ptr <= (REQ.op == IOPC_OP_STR_WR) ? REQ.source_ptr_reg : REQ.dest_ptr_reg;
      count <= REQ.count;
    end
    else if (state == ST_NEXT)
    begin
      // R16 pointer steps by element size
      ptr <= STEP_DIRECTION_FLAG ? (ptr - step) : (ptr + step);
      if (req.block_loop_prefix)
      begin
        count <= count - 32'h00000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // threshold and irq allow flag
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      thr <= IOPC_THR_RST;
      irq <= IOPC_IRQ_RST;
    end
    else if (state == ST_IDLE && REQ_VALID)
    begin
      case (REQ.op)
        IOPC_OP_FLAGS_RESTORE:
        begin
          // R2 threshold written only at level 0
          if (RUNNING_PRIV_LEVEL == IOPC_PRIV_TOP)
          begin
            thr <= REQ.new_threshold;
          end
          // R3 irq flag kept silently above threshold
          if (irq_ok)
          begin
            irq <= REQ.new_irq_allow;
          end
        end
        IOPC_OP_TRAP_RETURN:
        begin
          // R2 trap return threshold at level 0
          if (RUNNING_PRIV_LEVEL == IOPC_PRIV_TOP)
          begin
            thr <= REQ.new_threshold;
          end
          irq <= REQ.new_irq_allow;
        end
        IOPC_OP_IRQ_MASK:
        begin
          if (irq_ok)
          begin
            irq <= 1'b0;
          end
        end
        IOPC_OP_IRQ_UNMASK:
        begin
          if (irq_ok)
          begin
            irq <= 1'b1;
          end
        end
        default:
        begin
          irq <= irq;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // check result, element data and accumulator
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      chk_ok <= 1'b0;
    end
    else if (state == ST_EVAL && !need_map && !(req.block_loop_prefix && count == 32'h00000000))
    begin
      chk_ok <= 1'b1;
    end
    else if (state == ST_MAP_RD && TCS_RD_VALID && !map_deny)
    begin
      chk_ok <= 1'b1;
    end
    else if (state == ST_IDLE || state == ST_NEXT)
    begin
      chk_ok <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      elem_data <= 32'h00000000;
      ACC_OUT <= 32'h00000000;
    end
    else if (state == ST_MEM_RD && MEM_RD_VALID)
    begin
      elem_data <= MEM_RD_DATA;
    end
    else if (state == ST_BUS && PBUS_ACK && !PBUS.write)
    begin
      // R14 single read lands in accumulator
      if (req.op == IOPC_OP_PORT_RD)
      begin
        ACC_OUT <= PBUS_RDATA;
      end
      else
      begin
        elem_data <= PBUS_RDATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion and fault pulses
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      DONE <= 1'b0;
      PROTECTION_FAULT <= 1'b0;
    end
    else
    begin
      DONE <= 1'b0;
      PROTECTION_FAULT <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (REQ_VALID && !is_port_op)
          begin
            // R1 irq ops refused above threshold
            if ((REQ.op == IOPC_OP_IRQ_MASK || REQ.op == IOPC_OP_IRQ_UNMASK) && !irq_ok)
            begin
              PROTECTION_FAULT <= 1'b1;
            end
            else
            begin
              DONE <= 1'b1;
            end
          end
        end
        ST_EVAL:
        begin
          if (req.block_loop_prefix && count == 32'h00000000)
          begin
            DONE <= 1'b1;
          end
          // R11 no map faults every checked access
          else if (need_map && map_none)
          begin
            PROTECTION_FAULT <= 1'b1;
          end
        end
        ST_MAP_RD:
        begin
          // R7 any set bit in the width faults
          if (TCS_RD_VALID && map_deny)
          begin
            PROTECTION_FAULT <= 1'b1;
          end
        end
        ST_BUS:
        begin
          if (PBUS_ACK && !is_str)
          begin
            DONE <= 1'b1;
          end
        end
        ST_NEXT:
        begin
          DONE <= last_elem;
        end
        default:
        begin
          DONE <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cacheability of the current memory access
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      LINE_CACHEABLE <= 1'b0;
    end
    else
    begin
      // R18 page no-cache bit wins
      LINE_CACHEABLE <= !CACHE_ALLOW_N && !PAGE_NOCACHE_BIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign REQ_READY = (state == ST_IDLE);
  // R12 bitmap fetch from the map base
  assign TCS_RD_REQ = (state == ST_MAP_RD);
  assign MEM_RD_REQ = (state == ST_MEM_RD);
  assign MEM_WR_REQ = (state == ST_MEM_WR);
  assign MEM_ADDR = ptr;
  assign MEM_WDATA = elem_data;
  assign PTR_OUT = ptr;
  assign COUNT_OUT = count;
  assign IO_PRIV_THRESHOLD = thr;
  assign IRQ_ALLOW = irq;
  // R20 bus cycle only after a passed check
  assign PBUS.valid = (state == ST_BUS) && chk_ok;
  assign PBUS.write = (req.op == IOPC_OP_PORT_WR) || (req.op == IOPC_OP_STR_WR);
  // R13 port space only
  assign PBUS.io_space = 1'b1;
  assign PBUS.addr = port_sel;
  assign PBUS.size = req.size;
  assign PBUS.wdata = (req.op == IOPC_OP_PORT_WR) ? req.accumulator_reg : elem_data;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  sequence s_irq_refused;
    state == ST_IDLE && REQ_VALID && PROT_MODE && (RUNNING_PRIV_LEVEL > thr) &&
      (REQ.op == IOPC_OP_IRQ_MASK || REQ.op == IOPC_OP_IRQ_UNMASK);
  endsequence

  sequence s_elem_stepped;
    state == ST_NEXT ##1 1'b1;
  endsequence

  AST_IRQ_FAULT: assert property (s_irq_refused |=> PROTECTION_FAULT && $stable(irq)) // R1
    else $error("irq op above threshold not refused");

  AST_THR_HOLD: assert property (state == ST_IDLE && REQ_VALID &&
      RUNNING_PRIV_LEVEL != IOPC_PRIV_TOP |=> $stable(thr)) // R2
    else $error("threshold changed away from level 0");

  AST_IRQ_KEEP: assert property (state == ST_IDLE && REQ_VALID && PROT_MODE &&
      REQ.op == IOPC_OP_FLAGS_RESTORE && RUNNING_PRIV_LEVEL > thr
      |=> $stable(irq) && !PROTECTION_FAULT) // R3
    else $error("flags restore changed irq flag or faulted");

  AST_NO_MAP_READ: assert property (state == ST_EVAL && PROT_MODE && !V86_MODE &&
      RUNNING_PRIV_LEVEL <= thr |=> !TCS_RD_REQ) // R4
    else $error("bitmap read within threshold");

  AST_V86_MAP_READ: assert property (state == ST_EVAL && V86_MODE && PROT_MODE &&
      !map_none && !(req.block_loop_prefix && count == 32'h00000000) |=> TCS_RD_REQ) // R5
    else $error("v86 access skipped the bitmap");

  AST_MAP_ADDR: assert property (TCS_RD_REQ |->
      TCS_RD_ADDR == {16'h0000, TCS_MAP_BASE} + {19'h00000, port_sel[15:3]}) // R6
    else $error("bitmap byte address wrong");

  AST_DENY_FAULT: assert property (state == ST_MAP_RD && TCS_RD_VALID && map_deny
      |=> PROTECTION_FAULT && state == ST_IDLE ##1 !PBUS.valid) // R7
    else $error("denied access did not fault");

  AST_NOMAP_FAULT: assert property (state == ST_EVAL && need_map && map_none &&
      !(req.block_loop_prefix && count == 32'h00000000) |=> PROTECTION_FAULT && !TCS_RD_REQ) // R11
    else $error("missing map did not fault");

  AST_BUS_CHECKED: assert property ($rose(PBUS.valid) |-> chk_ok && !PROTECTION_FAULT &&
      (!need_map || $past(state) == ST_MAP_RD || $past(state) == ST_MEM_RD)) // R20
    else $error("bus cycle before check");

  AST_IO_SPACE: assert property (PBUS.valid |-> PBUS.io_space && !MEM_RD_REQ && !MEM_WR_REQ) // R13
    else $error("port op touched memory space");

  AST_PTR_STEP: assert property (s_elem_stepped |-> ptr == ($past(STEP_DIRECTION_FLAG) ?
      $past(ptr) - $past(step) : $past(ptr) + $past(step))) // R16
    else $error("pointer step wrong");

  AST_NOCACHE: assert property (PAGE_NOCACHE_BIT |=> !LINE_CACHEABLE) // R18
    else $error("no-cache page cached");

endmodule

/* File: bench/iopc_port_dev.sv */
// far-side model: task segment bitmap, memory, port devices, address decode
module iopc_port_dev
  import iopc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [31:0] dec_addr,
  input wire logic tcs_rd_req,
  input wire logic [31:0] tcs_rd_addr,
  output logic tcs_rd_valid,
  output logic [15:0] tcs_rd_data,
  input wire logic mem_rd_req,
  input wire logic mem_wr_req,
  input wire logic [31:0] mem_addr,
  output logic mem_rd_valid,
  output logic [31:0] mem_rd_data,
  output logic mem_wr_ack,
  input iopc_pbus_t pbus,
  output logic pbus_ack,
  output logic [31:0] pbus_rdata,
  output logic cache_allow_n
);
  logic [7:0] tcs_mem [0:255];
  logic [31:0] junk;
  logic [1:0] wait_cnt;
  logic busy;
  assign busy = tcs_rd_valid | mem_rd_valid | mem_wr_ack | pbus_ack;
  // answers come one or more cycles late; idle data lines carry a moving pattern
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      {tcs_rd_valid, mem_rd_valid, mem_wr_ack, pbus_ack} <= 4'h0;
      wait_cnt <= 2'h0;
      junk <= 32'h5A5A5A5A;
    end
    else
    begin
      junk <= junk + 32'h9E3779B9;
      {tcs_rd_valid, mem_rd_valid, mem_wr_ack, pbus_ack} <= 4'h0;
      if ((tcs_rd_req | mem_rd_req | mem_wr_req | pbus.valid) && !busy)
      begin
        if (wait_cnt != 2'h0)
          wait_cnt <= wait_cnt - 2'h1;
        else
        begin
          wait_cnt <= slow ? 2'($urandom) : 2'h0;
          {tcs_rd_valid, mem_rd_valid} <= {tcs_rd_req, mem_rd_req};
          {mem_wr_ack, pbus_ack} <= {mem_wr_req, pbus.valid};
        end
      end
    end
  assign tcs_rd_data = tcs_rd_valid ?
    {tcs_mem[tcs_rd_addr[7:0] + 8'h01], tcs_mem[tcs_rd_addr[7:0]]} : junk[15:0];
  assign mem_rd_data = mem_rd_valid ? ~mem_addr : junk;
  assign pbus_rdata = pbus_ack ? {pbus.addr, ~pbus.addr} : junk;
  assign cache_allow_n = dec_addr[31:28] == 4'hF;
endmodule

/* File: bench/tb_iopc_checker.sv */
// self-checking bench of the port access checker
module tb_iopc_checker
  import iopc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic REF_CLK, RESETN, REQ_VALID, REQ_READY, PROT_MODE, V86_MODE, STEP_DIRECTION_FLAG;
  logic [1:0] RUNNING_PRIV_LEVEL, IO_PRIV_THRESHOLD;
  logic [15:0] TCS_MAP_BASE, TCS_RD_DATA;
  logic [31:0] TCS_LIMIT, TCS_RD_ADDR, MEM_ADDR, MEM_WDATA, MEM_RD_DATA, PBUS_RDATA;
  logic [31:0] ACC_OUT, PTR_OUT, COUNT_OUT;
  logic TCS_RD_REQ, TCS_RD_VALID, MEM_RD_REQ, MEM_WR_REQ, MEM_RD_VALID, MEM_WR_ACK;
  logic PBUS_ACK, DONE, PROTECTION_FAULT, IRQ_ALLOW, CACHE_ALLOW_N, PAGE_NOCACHE_BIT;
  logic LINE_CACHEABLE;
  iopc_req_t REQ, r;
  iopc_pbus_t PBUS, pb;
  int i, nb, ne, n_pbus, n_tcs, n_mem, num_errors, n_compared, cyc;
  logic got_d, got_f, ef, need, prot, v86, dir, mirq, slow;
  logic [1:0] lvl, sz, mthr;
  logic [15:0] base, port;
  logic [31:0] lim, tcs_a, mem_a, mw, ptr, m, dec_addr;

  iopc_checker i_dut (.*);
  iopc_port_dev i_dev (.clk(REF_CLK), .rst_n(RESETN), .slow(slow), .dec_addr(dec_addr),
    .tcs_rd_req(TCS_RD_REQ), .tcs_rd_addr(TCS_RD_ADDR), .tcs_rd_valid(TCS_RD_VALID),
    .tcs_rd_data(TCS_RD_DATA), .mem_rd_req(MEM_RD_REQ), .mem_wr_req(MEM_WR_REQ),
    .mem_addr(MEM_ADDR), .mem_rd_valid(MEM_RD_VALID), .mem_rd_data(MEM_RD_DATA),
    .mem_wr_ack(MEM_WR_ACK), .pbus(PBUS), .pbus_ack(PBUS_ACK), .pbus_rdata(PBUS_RDATA),
    .cache_allow_n(CACHE_ALLOW_N));

  always #2.5 REF_CLK = ~REF_CLK;

  task automatic chk(logic [63:0] got, logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watch the buses
  always @(posedge REF_CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      finish_test();
    end
    if (PBUS.valid && PBUS_ACK)
    begin
      n_pbus++;
      pb = PBUS;
      chk(PBUS.io_space, 1'b1);
    end
    if (TCS_RD_REQ && TCS_RD_VALID)
    begin
      n_tcs++;
      tcs_a = TCS_RD_ADDR;
    end
    if ((MEM_RD_REQ && MEM_RD_VALID) || (MEM_WR_REQ && MEM_WR_ACK))
    begin
      n_mem++;
      mem_a = MEM_ADDR;
      mw = MEM_WDATA;
    end
  end

  task automatic run();
    n_pbus = 0;
    n_tcs = 0;
    n_mem = 0;
    @(posedge REF_CLK);
    {PROT_MODE, V86_MODE, STEP_DIRECTION_FLAG} <= {prot, v86, dir};
    {RUNNING_PRIV_LEVEL, TCS_MAP_BASE, TCS_LIMIT} <= {lvl, base, lim};
    REQ <= r;
    REQ_VALID <= 1'b1;
    @(posedge REF_CLK);
    REQ_VALID <= 1'b0;
    {got_d, got_f} = 2'h0;
    for (int k = 0; k < 300 && !(got_d || got_f); k++)
    begin
      #1;
      {got_d, got_f} = {DONE, PROTECTION_FAULT};
      if (!(got_d || got_f))
        @(posedge REF_CLK);
    end
  endtask

  function automatic logic exp_fault(logic [15:0] pt, int n);
    logic [16:0] p;
    if (!need)
      return 1'b0;
    if (base >= lim || base + (pt >> 3) + 1 > lim)
      return 1'b1;
    for (int k = 0; k < n; k++)
    begin
      p = pt + k;
      if (p > IOPC_PORT_LAST || i_dev.tcs_mem[8'(base + (p >> 3))][p[2:0]])
        return 1'b1;
    end
    return 1'b0;
  endfunction

  function automatic logic [31:0] msk(int n);
    return n == 4 ? 32'hFFFFFFFF : (32'h1 << (8 * n)) - 32'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  initial
  begin
    {REF_CLK, RESETN, REQ_VALID, PROT_MODE, V86_MODE, STEP_DIRECTION_FLAG} = 6'h0;
    {RUNNING_PRIV_LEVEL, TCS_MAP_BASE, TCS_LIMIT, PAGE_NOCACHE_BIT} = '0;
    {REQ, r, slow, dec_addr, prot, v86, dir, lvl, base, lim} = '0;
    {num_errors, n_compared, cyc, mthr, mirq} = '0;
    void'($urandom(32'h2F81CCC5));
    for (i = 0; i < 256; i++)
      i_dev.tcs_mem[i] = 8'($urandom & $urandom & $urandom);
    repeat (2) @(posedge REF_CLK);
    RESETN <= 1'b1;
    #1;
    chk({IO_PRIV_THRESHOLD, IRQ_ALLOW, REQ_READY}, {IOPC_THR_RST, IOPC_IRQ_RST, 1'b1});
    prot = 1'b1;
    for (i = 0; i < 8; i++)
    begin
      lvl = 2'(i);
      r = '0;
      r.op = i < 4 ? IOPC_OP_FLAGS_RESTORE : IOPC_OP_TRAP_RETURN;
      r.new_threshold = 2'($urandom);
      r.new_irq_allow = ~mirq;
      run();
      if (i >= 4 || lvl <= mthr)
        mirq = r.new_irq_allow;
      if (lvl == 2'h0)
        mthr = r.new_threshold;
      chk({got_d, got_f}, 2'h2);
      chk(IO_PRIV_THRESHOLD, mthr);
      chk(IRQ_ALLOW, mirq);
    end
    lvl = 2'h0;
    r.op = IOPC_OP_FLAGS_RESTORE;
    r.new_threshold = 2'h1;
    run();
    mthr = 2'h1;
    for (i = 0; i < 8; i++)
    begin
      lvl = 2'(i);
      r.op = i < 4 ? IOPC_OP_IRQ_MASK : IOPC_OP_IRQ_UNMASK;
      run();
      if (lvl <= mthr)
        mirq = i >= 4;
      chk(got_f, lvl > mthr);
      chk(IRQ_ALLOW, mirq);
    end
    for (i = 0; i < 90; i++)
    begin
      {prot, v86, lvl, slow} = {$urandom % 8 != 0, $urandom % 3 == 0, 2'($urandom), 1'($urandom)};
      {base, lim, sz} = {16'($urandom % 64), 32'($urandom % 256), 2'($urandom % 3)};
      port = i == 0 ? 16'hFFFD : 16'($urandom % 1600);
      nb = 1 << sz;
      if (base + (port >> 3) == lim && port[2:0] + nb <= 8)
        lim++;
      i_dev.tcs_mem[lim[7:0]] = 8'hFF;
      r = '0;
      r.op = $urandom % 2 ? IOPC_OP_PORT_WR : IOPC_OP_PORT_RD;
      {r.size, r.imm_port, r.accumulator_reg} = {iopc_sz_t'(sz), 1'($urandom), $urandom};
      r.imm = r.imm_port ? port : ~port;
      r.port_number_reg = r.imm_port ? ~port : port;
      need = prot && (v86 || lvl > mthr);
      ef = exp_fault(port, nb);
      m = msk(nb);
      run();
      chk(got_f, ef);
      if (i > 0)
        chk(n_tcs, need && base < lim);
      if (n_tcs != 0)
        chk(tcs_a, base + (port >> 3));
      chk({n_pbus, n_mem}, {32'(!ef), 32'h0});
      if (!ef)
      begin
        chk({pb.addr, pb.size, pb.write}, {port, sz, r.op == IOPC_OP_PORT_WR});
        if (pb.write)
          chk(pb.wdata & m, r.accumulator_reg & m);
        else
          chk(ACC_OUT & m, {port, ~port} & m);
      end
    end
    {prot, v86, lvl} = 4'h8;
    for (i = 0; i < 5; i++)
    begin
      {dir, sz} = {1'(i), 2'($urandom % 3)};
      nb = 1 << sz;
      ne = i == 3 ? 1 : 3;
      m = msk(nb);
      r = '0;
      r.op = i < 2 ? IOPC_OP_STR_WR : IOPC_OP_STR_RD;
      {r.size, r.block_loop_prefix, r.count} = {iopc_sz_t'(sz), 1'(i != 3), i == 4 ? 32'h0 : 32'h3};
      {r.port_number_reg, r.source_ptr_reg, r.dest_ptr_reg} = {16'($urandom), $urandom, $urandom};
      ptr = r.op == IOPC_OP_STR_WR ? r.source_ptr_reg : r.dest_ptr_reg;
      run();
      if (i == 4)
        chk({got_d, 32'(n_pbus + n_mem)}, {1'b1, 32'h0});
      else
      begin
        chk({n_pbus, n_mem}, {32'(ne), 32'(ne)});
        chk(PTR_OUT, dir ? ptr - ne * nb : ptr + ne * nb);
        chk(COUNT_OUT, i == 3 ? 32'h3 : 32'h0);
        chk(mem_a, dir ? ptr - (ne - 1) * nb : ptr + (ne - 1) * nb);
        chk(pb.addr, r.port_number_reg);
        if (i < 2)
          chk(pb.wdata & m, ~mem_a & m);
        else
          chk(mw & m, {pb.addr, ~pb.addr} & m);
      end
    end
    for (i = 0; i < 4; i++)
    begin
      @(posedge REF_CLK);
      PAGE_NOCACHE_BIT <= i[0];
      dec_addr <= i[1] ? 32'hF0000000 : 32'h00001000;
      repeat (2) @(posedge REF_CLK);
      #1;
      chk(LINE_CACHEABLE, i == 0);
    end
    finish_test();
  end
endmodule
